// ---- core/dsf_top.sv ----
// dual nine-bit fifo channels with avalon register slave
//
// Decided for this implementation: the address map and register access over Avalon-MM.
`timescale 1ns/100ps
module dsf_top #(
   parameter int DEPTH = dsf_pkg::DEPTH_DEF
) (
   input  wire logic                        core_clk,
   input  wire logic                        rst,
   input  wire logic [dsf_pkg::AVS_AW-1:0]  avs_address,
   input  wire logic                        avs_read,
   input  wire logic                        avs_write,
   input  wire logic [31:0]                 avs_writedata,
   output logic      [31:0]                 avs_readdata,
   output logic                             avs_waitrequest,
   input  wire logic [dsf_pkg::NCH-1:0]     ch_rst_n,
   input  wire dsf_pkg::dsf_wr_t            wr_pins [dsf_pkg::NCH],
   input  wire dsf_pkg::dsf_rd_t            rd_pins [dsf_pkg::NCH],
   output logic [dsf_pkg::DATA_W-1:0]       rd_data_out [dsf_pkg::NCH],
   output logic [dsf_pkg::NCH-1:0]          rd_data_oe,
   output dsf_pkg::dsf_flag_t               flags [dsf_pkg::NCH]
);
   localparam int PW = $clog2(DEPTH);

   // ----------------------------------------------------------------
   // shared between bus and channels
   // ----------------------------------------------------------------
   logic [31:0]             stat_a  [dsf_pkg::NCH];
   logic [31:0]             lvl_a   [dsf_pkg::NCH];
   logic [dsf_pkg::OFF_W-1:0] eoff_a [dsf_pkg::NCH];
   logic [dsf_pkg::OFF_W-1:0] foff_a [dsf_pkg::NCH];
   logic [dsf_pkg::NCH-1:0] bus_we_eoff;
   logic [dsf_pkg::NCH-1:0] bus_we_foff;

   // ----------------------------------------------------------------
   // avalon slave
   // ----------------------------------------------------------------
   logic        wait_r;
   logic        wait_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic        req;
   logic        sel_ch;
   logic [1:0]  sel_reg;
   logic        mapped;

   assign req     = avs_read | avs_write;
   assign sel_ch  = avs_address[dsf_pkg::CH_BIT];
   assign sel_reg = avs_address[3:2];
   assign mapped  = ~avs_address[dsf_pkg::MAP_BIT];

   // ----------------------------------------------------------------
   // request decode and answer
   // ----------------------------------------------------------------
   always_comb begin
      wait_nxt    = 1'b1;
      rdata_nxt   = rdata_r;
      bus_we_eoff = '0;
      bus_we_foff = '0;
      if (req && wait_r) begin
         wait_nxt  = 1'b0;
         rdata_nxt = 32'h00000000;
         if (avs_read && mapped) begin
            unique case (sel_reg)
               dsf_pkg::REG_EOFF: rdata_nxt = 32'(eoff_a[sel_ch]);
               dsf_pkg::REG_FOFF: rdata_nxt = 32'(foff_a[sel_ch]);
               dsf_pkg::REG_STAT: rdata_nxt = stat_a[sel_ch];
               dsf_pkg::REG_LVL:  rdata_nxt = lvl_a[sel_ch];
            endcase
         end
      end
      if (avs_write && !wait_r && mapped) begin
         if (sel_reg == dsf_pkg::REG_EOFF) begin
            bus_we_eoff[sel_ch] = 1'b1;
         end
         if (sel_reg == dsf_pkg::REG_FOFF) begin
            bus_we_foff[sel_ch] = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         wait_r  <= 1'b1;
         rdata_r <= 32'h00000000;
      end else begin
         wait_r  <= wait_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign avs_waitrequest = wait_r;
   assign avs_readdata    = rdata_r;

   // ----------------------------------------------------------------
   // fifo channels
   // ----------------------------------------------------------------
   for (genvar c = 0; c < dsf_pkg::NCH; c++) begin : g_ch
      logic                      wr_rise;
      logic                      rd_rise;
      logic                      crst;
      logic                      wen1_n;
      logic                      wen2_n;
      logic                      ren_ok;
      logic                      do_wr;
      logic                      do_rd;
      logic                      do_ld;
      logic [PW:0]               wp_r;
      logic [PW:0]               wp_nxt;
      logic [PW:0]               rp_r;
      logic [PW:0]               rp_nxt;
      logic [PW:0]               lvl_nxt;
      logic [PW:0]               lvl_cur;
      logic [dsf_pkg::DATA_W-1:0] q_r;
      logic [dsf_pkg::DATA_W-1:0] q_nxt;
      logic                      oe_r;
      logic                      oe_nxt;
      logic                      full_n_r;
      logic                      full_n_nxt;
      logic                      afull_n_r;
      logic                      afull_n_nxt;
      logic                      empty_n_r;
      logic                      empty_n_nxt;
      logic                      aempt_n_r;
      logic                      aempt_n_nxt;
      logic                      mode_r;
      logic                      mode_nxt;
      logic [1:0]                ldsel_r;
      logic [1:0]                ldsel_nxt;
      logic [dsf_pkg::OFF_W-1:0] eoff_r;
      logic [dsf_pkg::OFF_W-1:0] eoff_nxt;
      logic [dsf_pkg::OFF_W-1:0] foff_r;
      logic [dsf_pkg::OFF_W-1:0] foff_nxt;
      logic [dsf_pkg::DATA_W-1:0] mem_r [DEPTH];

      // -------------------------------------------------------------
      // pin clock edges, one pair per channel
      // -------------------------------------------------------------
      dsf_edge u_wr_edge (
         .core_clk (core_clk),
         .rst      (rst),
         .pin      (wr_pins[c].wr_clk),
         .rise     (wr_rise)
      );

      dsf_edge u_rd_edge (
         .core_clk (core_clk),
         .rst      (rst),
         .pin      (rd_pins[c].rd_clk),
         .rise     (rd_rise)
      );

      // -------------------------------------------------------------
      // enables and accepted transfers
      // -------------------------------------------------------------
      assign crst   = rst | ~ch_rst_n[c];
      assign wen1_n = wr_pins[c].wr_en_first_n;
      assign wen2_n = wr_pins[c].wr_en_second_or_load_n;
      assign ren_ok = ~rd_pins[c].rd_en_first_n & ~rd_pins[c].rd_en_second_n;

      // writes need first enable low and second pin high in either mode
      assign do_wr = wr_rise & ~wen1_n & wen2_n & full_n_r;
      // offset loading only in programmable mode with load pin low
      assign do_ld = wr_rise & ~wen1_n & ~wen2_n & ~mode_r;
      // reads need both enables low and a non-empty flag
      assign do_rd = rd_rise & ren_ok & empty_n_r;

      // -------------------------------------------------------------
      // next state
      // -------------------------------------------------------------
      always_comb begin
         wp_nxt      = wp_r + (PW+1)'(do_wr);
         rp_nxt      = rp_r + (PW+1)'(do_rd);
         lvl_nxt     = wp_nxt - rp_nxt;
         q_nxt       = do_rd ? mem_r[rp_r[PW-1:0]] : q_r;
         oe_nxt      = rst ? 1'b0 : ~rd_pins[c].out_drive_en_n;
         full_n_nxt  = full_n_r;
         afull_n_nxt = afull_n_r;
         empty_n_nxt = empty_n_r;
         aempt_n_nxt = aempt_n_r;
         mode_nxt    = mode_r;
         ldsel_nxt   = ldsel_r;
         eoff_nxt    = eoff_r;
         foff_nxt    = foff_r;
         if (wr_rise) begin
            full_n_nxt  = 32'(lvl_nxt) != DEPTH;
            afull_n_nxt = (32'(lvl_nxt) + 32'(foff_r)) < DEPTH;
         end
         if (rd_rise) begin
            empty_n_nxt = lvl_nxt != '0;
            aempt_n_nxt = 32'(lvl_nxt) > 32'(eoff_r);
         end
         if (do_ld) begin
            ldsel_nxt = ldsel_r + 2'h1;
            unique case (ldsel_r)
               2'h0: eoff_nxt[7:0]  = wr_pins[c].wr_data_in[7:0];
               2'h1: eoff_nxt[15:8] = wr_pins[c].wr_data_in[7:0];
               2'h2: foff_nxt[7:0]  = wr_pins[c].wr_data_in[7:0];
               2'h3: foff_nxt[15:8] = wr_pins[c].wr_data_in[7:0];
            endcase
         end else begin
            if (bus_we_eoff[c]) begin
               eoff_nxt = avs_writedata[dsf_pkg::OFF_W-1:0];
            end
            if (bus_we_foff[c]) begin
               foff_nxt = avs_writedata[dsf_pkg::OFF_W-1:0];
            end
         end
         if (!wen2_n == 1'b0) begin
            ldsel_nxt = do_ld ? ldsel_nxt : ldsel_r;
         end
         if (crst) begin
            wp_nxt      = '0;
            rp_nxt      = '0;
            full_n_nxt  = 1'b1;
            afull_n_nxt = 1'b1;
            empty_n_nxt = 1'b0;
            aempt_n_nxt = 1'b0;
            q_nxt       = '0;
            eoff_nxt    = dsf_pkg::EOFF_RST;
            foff_nxt    = dsf_pkg::FOFF_RST;
            ldsel_nxt   = 2'h0;
            mode_nxt    = wen2_n;
         end
      end

      // -------------------------------------------------------------
      // channel registers
      // -------------------------------------------------------------
      always_ff @(posedge core_clk) begin
         wp_r      <= wp_nxt;
         rp_r      <= rp_nxt;
         q_r       <= q_nxt;
         oe_r      <= oe_nxt;
         full_n_r  <= full_n_nxt;
         afull_n_r <= afull_n_nxt;
         empty_n_r <= empty_n_nxt;
         aempt_n_r <= aempt_n_nxt;
         mode_r    <= mode_nxt;
         ldsel_r   <= ldsel_nxt;
         eoff_r    <= eoff_nxt;
         foff_r    <= foff_nxt;
      end

      // -------------------------------------------------------------
      // storage, one word per accepted write edge
      // -------------------------------------------------------------
      always_ff @(posedge core_clk) begin
         if (do_wr) begin
            mem_r[wp_r[PW-1:0]] <= wr_pins[c].wr_data_in;
         end
      end

      // -------------------------------------------------------------
      // outputs and bus views
      // -------------------------------------------------------------
      assign rd_data_out[c]               = q_r;
      assign rd_data_oe[c]                = oe_r;
      assign flags[c].full_flag_n         = full_n_r;
      assign flags[c].almost_full_flag_n  = afull_n_r;
      assign flags[c].almost_empty_flag_n = aempt_n_r;
      assign flags[c].empty_flag_n        = empty_n_r;
      assign eoff_a[c]                    = eoff_r;
      assign foff_a[c]                    = foff_r;
      // level wraps at pointer width before it is widened
      assign lvl_cur                      = wp_r - rp_r;
      assign lvl_a[c]                     = 32'(lvl_cur);

      // -------------------------------------------------------------
      // status word
      // -------------------------------------------------------------
      always_comb begin
         stat_a[c]                     = 32'h00000000;
         stat_a[c][dsf_pkg::ST_FULL_N]  = full_n_r;
         stat_a[c][dsf_pkg::ST_AFULL_N] = afull_n_r;
         stat_a[c][dsf_pkg::ST_AEMPT_N] = aempt_n_r;
         stat_a[c][dsf_pkg::ST_EMPTY_N] = empty_n_r;
         stat_a[c][dsf_pkg::ST_MODE]    = mode_r;
      end
   end
endmodule

// ---- include/dsf_pkg.sv ----
// constants and carrier types for the dual nine-bit fifo
package dsf_pkg;
   // ----------------------------------------------------------------
   // geometry
   // ----------------------------------------------------------------
   localparam int DATA_W    = 9;
   localparam int NCH       = 2;
   localparam int DEPTH_DEF = 256;
   localparam int OFF_W     = 16;
   localparam int AVS_AW    = 6;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] EOFF_RST = 16'h0007;
   localparam logic [15:0] FOFF_RST = 16'h0007;

   // ----------------------------------------------------------------
   // register map, byte addresses, channel stride 0x10
   // ----------------------------------------------------------------
   localparam logic [1:0] REG_EOFF  = 2'h0;
   localparam logic [1:0] REG_FOFF  = 2'h1;
   localparam logic [1:0] REG_STAT  = 2'h2;
   localparam logic [1:0] REG_LVL   = 2'h3;
   localparam int         CH_BIT    = 4;
   localparam int         MAP_BIT   = 5;

   // status field positions
   localparam int ST_FULL_N  = 0;
   localparam int ST_AFULL_N = 1;
   localparam int ST_AEMPT_N = 2;
   localparam int ST_EMPTY_N = 3;
   localparam int ST_MODE    = 4;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic              wr_clk;
      logic              wr_en_first_n;
      logic              wr_en_second_or_load_n;
      logic [DATA_W-1:0] wr_data_in;
   } dsf_wr_t;

   typedef struct packed {
      logic rd_clk;
      logic rd_en_first_n;
      logic rd_en_second_n;
      logic out_drive_en_n;
   } dsf_rd_t;

   typedef struct packed {
      logic full_flag_n;
      logic almost_full_flag_n;
      logic almost_empty_flag_n;
      logic empty_flag_n;
   } dsf_flag_t;
endpackage

// ---- core/dsf_edge.sv ----
// rising edge detector for a sampled pin clock
`timescale 1ns/100ps
module dsf_edge (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic pin,
   output logic      rise
);
   logic prev_r;
   logic prev_nxt;

   always_comb begin
      prev_nxt = pin;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         prev_r <= 1'b0;
      end else begin
         prev_r <= prev_nxt;
      end
   end

   assign rise = pin & ~prev_r;
endmodule

// ---- tb/dsf_top_monitor.sv ----
// concurrent checks on the dual fifo ports, channel zero
`timescale 1ns/100ps
module dsf_mon (
   input wire logic                       core_clk,
   input wire logic                       rst,
   input wire logic [dsf_pkg::AVS_AW-1:0] avs_address,
   input wire logic                       avs_read,
   input wire logic                       avs_write,
   input wire logic [31:0]                avs_readdata,
   input wire logic                       avs_waitrequest,
   input wire logic [dsf_pkg::NCH-1:0]    ch_rst_n,
   input wire dsf_pkg::dsf_wr_t           wr_pins [dsf_pkg::NCH],
   input wire dsf_pkg::dsf_rd_t           rd_pins [dsf_pkg::NCH],
   input wire logic [dsf_pkg::DATA_W-1:0] rd_data_out [dsf_pkg::NCH],
   input wire logic [dsf_pkg::NCH-1:0]    rd_data_oe,
   input wire dsf_pkg::dsf_flag_t         flags [dsf_pkg::NCH]
);
   logic [2:0] hist_r;
   logic [2:0] hist_nxt;
   logic       wr_rise;
   logic       rd_rise;
   logic       rd_take;
   // ---------------------------------
   // pin clock history
   // ---------------------------------
   always_comb begin
      hist_nxt = {rst | ~ch_rst_n[0], wr_pins[0].wr_clk & ~rst,
                  rd_pins[0].rd_clk & ~rst};
   end
   always_ff @(posedge core_clk) begin
      hist_r <= hist_nxt;
   end
   assign wr_rise = wr_pins[0].wr_clk & ~hist_r[1];
   assign rd_rise = rd_pins[0].rd_clk & ~hist_r[0];
   assign rd_take = rd_rise & ~rd_pins[0].rd_en_first_n
                  & ~rd_pins[0].rd_en_second_n & flags[0].empty_flag_n;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst || !ch_rst_n[0]);
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_ans;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   a_reset_flags: assert property (@(posedge core_clk) disable iff (1'b0)
      (rst || !ch_rst_n[0]) |=> flags[0] == 4'hC && rd_data_out[0] == '0)
      else $error("flags or output not at reset values");
   a_wr_sync: assert property (!hist_r[2] && !$stable({flags[0].full_flag_n,
      flags[0].almost_full_flag_n}) |-> $past(wr_rise))
      else $error("full flags moved without write clock rise");
   a_rd_sync: assert property (!hist_r[2] && !$stable({flags[0].empty_flag_n,
      flags[0].almost_empty_flag_n}) |-> $past(rd_rise))
      else $error("empty flags moved without read clock rise");
   a_q_hold: assert property (!rd_take |=> $stable(rd_data_out[0]))
      else $error("output register changed without a read");
   a_oe_follow: assert property (1'b1 |=>
      rd_data_oe[0] == !$past(rd_pins[0].out_drive_en_n))
      else $error("drive enable does not follow pin");
   a_full_afull: assert property (!flags[0].full_flag_n |->
      !flags[0].almost_full_flag_n) else $error("full without almost full");
   a_empty_aempty: assert property (!flags[0].empty_flag_n |->
      !flags[0].almost_empty_flag_n) else $error("empty without almost empty");
   a_bus_wait: assert property (s_req |=> s_ans)
      else $error("bus answer not after one wait cycle");
   a_unmapped_read: assert property (avs_read && avs_address[5] &&
      !avs_waitrequest |-> avs_readdata == '0) else $error("unmapped read not 0");
endmodule
bind dsf_top dsf_mon i_mon (.core_clk, .rst, .avs_address, .avs_read,
   .avs_write, .avs_readdata, .avs_waitrequest, .ch_rst_n, .wr_pins,
   .rd_pins, .rd_data_out, .rd_data_oe, .flags);

// ---- tb/dsf_peer.sv ----
// writer and reader logic facing both fifo channels
`timescale 1ns/100ps
module dsf_peer (
   input  wire logic        core_clk,
   output dsf_pkg::dsf_wr_t wr_pins [dsf_pkg::NCH],
   output dsf_pkg::dsf_rd_t rd_pins [dsf_pkg::NCH]
);
   initial begin
      wr_pins[0] = 12'h600;
      wr_pins[1] = 12'h400;
      rd_pins[0] = 4'h7;
      rd_pins[1] = 4'h7;
   end
   task automatic put(input int c, input logic en, input logic ld,
                      input logic [8:0] d, input int gap);
      repeat (gap) @(posedge core_clk);
      @(posedge core_clk);
      wr_pins[c].wr_en_first_n <= en;
      wr_pins[c].wr_en_second_or_load_n <= ld;
      wr_pins[c].wr_data_in <= d;
      @(posedge core_clk);
      wr_pins[c].wr_clk <= 1'b1;
      @(posedge core_clk);
      wr_pins[c].wr_clk <= 1'b0;
      wr_pins[c].wr_en_first_n <= 1'b1;
      wr_pins[c].wr_data_in <= ~d;
   endtask
   task automatic get(input int c, input logic e1, e2, input int gap);
      repeat (gap) @(posedge core_clk);
      @(posedge core_clk);
      rd_pins[c].rd_en_first_n <= e1;
      rd_pins[c].rd_en_second_n <= e2;
      @(posedge core_clk);
      rd_pins[c].rd_clk <= 1'b1;
      @(posedge core_clk);
      rd_pins[c].rd_clk <= 1'b0;
      rd_pins[c].rd_en_first_n <= 1'b1;
   endtask
   task automatic oe(input int c, input logic v);
      @(posedge core_clk);
      rd_pins[c].out_drive_en_n <= v;
      @(posedge core_clk);
   endtask
endmodule

// ---- tb/dsf_top_bench.sv ----
// self-checking bench for the dual nine-bit fifo
`timescale 1ns/100ps
module dsf_top_bench;
   logic               core_clk;
   logic               rst;
   logic [5:0]         avs_address;
   logic               avs_read;
   logic               avs_write;
   logic [31:0]        avs_writedata;
   logic [31:0]        avs_readdata;
   logic               avs_waitrequest;
   logic [1:0]         ch_rst_n;
   logic [1:0]         rd_data_oe;
   dsf_pkg::dsf_wr_t   wr_pins [dsf_pkg::NCH];
   dsf_pkg::dsf_rd_t   rd_pins [dsf_pkg::NCH];
   logic [8:0]         rd_data_out [dsf_pkg::NCH];
   dsf_pkg::dsf_flag_t flags [dsf_pkg::NCH];
   logic [8:0]         m_q [$];
   logic [8:0]         exp_q [$];
   logic [8:0]         last;
   logic [31:0]        rv;
   logic [5:0]         ra [5] = '{6'h00, 6'h04, 6'h08, 6'h18, 6'h20};
   logic [31:0]        rx [5] = '{32'h7, 32'h7, 32'h13, 32'h3, 32'h0};
   logic [8:0]         ld [5] = '{9'h0AA, 9'h001, 9'h155, 9'h002, 9'h003};
   int                 failures = 0;
   int                 check_count = 0;
   int                 seed = 97;
   dsf_top i_dsf_top (.core_clk, .rst, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_readdata, .avs_waitrequest, .ch_rst_n, .wr_pins,
      .rd_pins, .rd_data_out, .rd_data_oe, .flags);
   dsf_peer i_dsf_peer (.core_clk, .wr_pins, .rd_pins);
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // ---------------------------------
   // shared tasks
   // ---------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic bus(input logic w, input logic [5:0] a,
                      input logic [31:0] d);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      rv = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wr0(input logic en);
      logic [8:0] d;
      d = 9'($random(seed));
      if (!en && m_q.size() < dsf_pkg::DEPTH_DEF) m_q.push_back(d);
      i_dsf_peer.put(0, en, 1'b1, d, $random(seed) & 1);
   endtask
   task automatic rd0(input logic e1, input logic e2);
      if (!e1 && !e2 && m_q.size() > 0) exp_q.push_back(m_q.pop_front());
      i_dsf_peer.get(0, e1, e2, $random(seed) & 1);
   endtask
   task automatic tend(input string s);
      $display("test %s done", s);
   endtask
   initial begin
      logic hit;
      logic pc;
      pc = 1'b0;
      forever begin
         @(posedge core_clk);
         hit = rd_pins[0].rd_clk && !pc && !rd_pins[0].rd_en_first_n
               && !rd_pins[0].rd_en_second_n && exp_q.size() > 0;
         pc = rd_pins[0].rd_clk;
         if (hit) begin
            #1 last = exp_q.pop_front();
            chk(rd_data_out[0], last);
         end
      end
   end
   initial begin
      #100000 failures++;
      print_verdict();
   end
   // ---------------------------------
   // main sequence
   // ---------------------------------
   initial begin
      rst = 1'b1;
      ch_rst_n = 2'h3;
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = '0;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      chk(flags[0], 4'hC);
      chk(rd_data_out[0], 9'h0);
      bus(1'b1, 6'h24, $random(seed));
      foreach (ra[i]) begin
         bus(1'b0, ra[i], 32'h0);
         chk(rv, rx[i]);
      end
      tend("reset");
      repeat (8) wr0(1'b0);
      wr0(1'b1);
      rd0(1'b1, 1'b0);
      @(negedge core_clk);
      chk(flags[0], 4'hF);
      chk(flags[1], 4'hC);
      rd0(1'b0, 1'b0);
      @(negedge core_clk);
      chk(flags[0].almost_empty_flag_n, 1'b0);
      rd0(1'b0, 1'b1);
      repeat (8) rd0(1'b0, 1'b0);
      @(negedge core_clk);
      chk(flags[0].empty_flag_n, 1'b0);
      chk(rd_data_out[0], last);
      i_dsf_peer.oe(0, 1'b0);
      @(negedge core_clk);
      chk(rd_data_oe, 2'h1);
      i_dsf_peer.oe(0, 1'b1);
      @(negedge core_clk);
      chk(rd_data_oe, 2'h0);
      tend("stream");
      repeat (248) wr0(1'b0);
      @(negedge core_clk);
      chk(flags[0].almost_full_flag_n, 1'b1);
      wr0(1'b0);
      @(negedge core_clk);
      chk(flags[0].almost_full_flag_n, 1'b0);
      repeat (8) wr0(1'b0);
      @(negedge core_clk);
      chk(flags[0].full_flag_n, 1'b0);
      rd0(1'b1, 1'b1);
      rd0(1'b0, 1'b0);
      wr0(1'b1);
      @(negedge core_clk);
      chk(flags[0].full_flag_n, 1'b1);
      repeat (256) rd0(1'b0, 1'b0);
      tend("fill");
      repeat (3) wr0(1'b0);
      ch_rst_n <= 2'h2;
      repeat (3) @(posedge core_clk);
      ch_rst_n <= 2'h3;
      m_q.delete();
      @(posedge core_clk);
      chk(flags[0], 4'hC);
      chk(rd_data_out[0], 9'h0);
      repeat (2) wr0(1'b0);
      rd0(1'b1, 1'b1);
      repeat (2) rd0(1'b0, 1'b0);
      tend("channel reset");
      foreach (ld[i]) i_dsf_peer.put(1, 1'b0, 1'b0, ld[i], 0);
      bus(1'b0, 6'h10, 32'h0);
      chk(rv, 32'h00000103);
      bus(1'b0, 6'h14, 32'h0);
      chk(rv, 32'h00000255);
      bus(1'b1, 6'h10, 32'h00000001);
      bus(1'b1, 6'h14, 32'h000000FE);
      bus(1'b0, 6'h14, 32'h0);
      chk(rv, 32'h000000FE);
      i_dsf_peer.put(1, 1'b0, 1'b1, 9'h1C3, 0);
      i_dsf_peer.put(1, 1'b0, 1'b1, 9'h03C, 0);
      i_dsf_peer.get(1, 1'b1, 1'b1, 0);
      @(negedge core_clk);
      chk(flags[1], 4'hB);
      bus(1'b0, 6'h1C, 32'h0);
      chk(rv, 32'h00000002);
      i_dsf_peer.get(1, 1'b0, 1'b0, 0);
      @(negedge core_clk);
      chk(rd_data_out[1], 9'h1C3);
      chk(flags[1].almost_empty_flag_n, 1'b0);
      tend("offsets");
      print_verdict();
   end
endmodule
